// ### verilog/qsg_status_top.sv
// Purpose: Doubtful condition status groups behind a command port.
// Assumes: Condition inputs come from other clock domains or pins.
// Notes:   Instrument preset is an input that touches no status word.
// How it works
// - Reading an event word returns it and clears it.
// - Reading a condition word returns it and leaves it unchanged.
// - Each group has a writable 16-bit enable mask for its summary.
// - Falling filter bit set latches event on condition 1 to 0.
// - Rising filter bit set latches event on condition 0 to 1.
// - Instrument preset leaves every status word unchanged.
// - Eight groups: adj channel, freq, limit x2, margin x2, power, sync.
`timescale 1ns/1ps
module qsg_status_top #(
  parameter int WIDTH  = qsg_pkg::WORD_W,
  parameter int GROUPS = qsg_pkg::NUM_GROUPS
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_preset,
  input  wire logic [GROUPS*WIDTH-1:0]       i_cond,
  input  wire logic                          i_req,
  input  wire logic [qsg_pkg::OP_W-1:0]      i_op,
  input  wire logic [qsg_pkg::SEL_W-1:0]     i_group,
  input  wire logic [WIDTH-1:0]              i_wdata,
  output logic                               o_rvalid,
  output logic [WIDTH-1:0]                   o_rdata,
  output logic [GROUPS-1:0]                  o_summary
);
  logic [GROUPS*WIDTH-1:0] cond_meta;
  logic [GROUPS*WIDTH-1:0] cond_sync;
  logic [WIDTH-1:0]        next_rdata;
  logic                    next_rvalid;
  logic [GROUPS-1:0]       sum_w;
  logic [WIDTH-1:0]        cond_w  [GROUPS];
  logic [WIDTH-1:0]        event_w [GROUPS];
  logic [WIDTH-1:0]        en_w    [GROUPS];
  logic [WIDTH-1:0]        fall_w  [GROUPS];
  logic [WIDTH-1:0]        rise_w  [GROUPS];

  // Conditions arrive asynchronously; two flops before any use.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cond_meta <= '0;
      cond_sync <= '0;
    end else begin
      cond_meta <= i_cond;
      cond_sync <= cond_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < GROUPS; gi++) begin : g_grp
      qsg_group_if #(.WIDTH(WIDTH)) gif ();
      logic sel;
      assign sel = i_req && (i_group == (qsg_pkg::SEL_W)'(gi));
      assign gif.cond_in   = cond_sync[gi*WIDTH +: WIDTH];
      assign gif.wdata     = i_wdata;
      assign gif.wr_enable = sel && (i_op == qsg_pkg::OP_WR_ENABLE);
      assign gif.wr_fall   = sel && (i_op == qsg_pkg::OP_WR_FALL);
      assign gif.wr_rise   = sel && (i_op == qsg_pkg::OP_WR_RISE);
      assign gif.clr_event = sel && (i_op == qsg_pkg::OP_RD_EVENT);
      assign sum_w[gi]   = gif.summary;
      assign cond_w[gi]  = gif.cond;
      assign event_w[gi] = gif.event_word;
      assign en_w[gi]    = gif.enable;
      assign fall_w[gi]  = gif.fall;
      assign rise_w[gi]  = gif.rise;
      qsg_group_core u_core (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .g     (gif)
      );
    end
  endgenerate

  // Read mux; the event word is captured before its clear lands.
  always_comb begin
    next_rdata  = '0;
    next_rvalid = 1'b0;
    if (i_req) begin
      case (i_op)
        qsg_pkg::OP_RD_EVENT: begin
          next_rvalid = 1'b1;
          next_rdata  = event_w[i_group];
        end
        qsg_pkg::OP_RD_COND: begin
          next_rvalid = 1'b1;
          next_rdata  = cond_w[i_group];
        end
        qsg_pkg::OP_RD_ENABLE: begin
          next_rvalid = 1'b1;
          next_rdata  = en_w[i_group];
        end
        qsg_pkg::OP_RD_FALL: begin
          next_rvalid = 1'b1;
          next_rdata  = fall_w[i_group];
        end
        qsg_pkg::OP_RD_RISE: begin
          next_rvalid = 1'b1;
          next_rdata  = rise_w[i_group];
        end
        default: begin
          next_rvalid = 1'b0;
          next_rdata  = '0;
        end
      endcase
    end
  end

  // Preset ignored.
  // Preset is deliberately not wired to any status storage.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
    end else begin
      o_rvalid <= next_rvalid;
      o_rdata  <= next_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) o_summary <= '0;
    else       o_summary <= sum_w;
  end
endmodule : qsg_status_top

// ### common/qsg_pkg.sv
// Purpose: Shared constants for the doubtful condition status groups.
// Assumes: Sixteen-bit status words, eight groups.
// Notes:   Group order is fixed by the index constants below.
package qsg_pkg;
  localparam int WORD_W     = 16;
  localparam int NUM_GROUPS = 8;
  localparam int SEL_W      = 3;
  localparam int OP_W       = 3;

  // Group indices.
  localparam logic [2:0] GRP_ACP    = 3'h0;
  localparam logic [2:0] GRP_FREQ   = 3'h1;
  localparam logic [2:0] GRP_LIM1   = 3'h2;
  localparam logic [2:0] GRP_LIM2   = 3'h3;
  localparam logic [2:0] GRP_MARG1  = 3'h4;
  localparam logic [2:0] GRP_MARG2  = 3'h5;
  localparam logic [2:0] GRP_POWER  = 3'h6;
  localparam logic [2:0] GRP_SYNC   = 3'h7;

  // Access operations.
  localparam logic [2:0] OP_RD_EVENT  = 3'h0;
  localparam logic [2:0] OP_RD_COND   = 3'h1;
  localparam logic [2:0] OP_WR_ENABLE = 3'h2;
  localparam logic [2:0] OP_WR_FALL   = 3'h3;
  localparam logic [2:0] OP_WR_RISE   = 3'h4;
  localparam logic [2:0] OP_RD_ENABLE = 3'h5;
  localparam logic [2:0] OP_RD_FALL   = 3'h6;
  localparam logic [2:0] OP_RD_RISE   = 3'h7;

  // Reset values.
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_FALL   = 16'h0000;
  localparam logic [15:0] RST_RISE   = 16'hffff;
endpackage : qsg_pkg

// ### common/qsg_group_if.sv
// Purpose: Carries one group's controls and results to a group core.
// Assumes: Single clock domain.
// Notes:   One instance per group.
`timescale 1ns/1ps
interface qsg_group_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] cond_in;
  logic             wr_enable;
  logic             wr_fall;
  logic             wr_rise;
  logic             clr_event;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] cond;
  logic [WIDTH-1:0] event_word;
  logic [WIDTH-1:0] enable;
  logic [WIDTH-1:0] fall;
  logic [WIDTH-1:0] rise;
  logic             summary;

  modport core (
    input  cond_in, wr_enable, wr_fall, wr_rise, clr_event, wdata,
    output cond, event_word, enable, fall, rise, summary
  );
  modport ctrl (
    output cond_in, wr_enable, wr_fall, wr_rise, clr_event, wdata,
    input  cond, event_word, enable, fall, rise, summary
  );
endinterface : qsg_group_if

// ### verilog/qsg_group_core.sv
// Purpose: One status group: condition, edge filters, event, enable.
// Assumes: cond_in already synchronised to i_clk.
// Notes:   A new event in the clearing cycle survives the clear.
`timescale 1ns/1ps
module qsg_group_core (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  qsg_group_if.core   g
);
  logic [qsg_pkg::WORD_W-1:0] next_event;
  logic [qsg_pkg::WORD_W-1:0] hit;

  always_ff @(posedge i_clk) begin
    if (i_rst) g.cond <= qsg_pkg::RST_WORD;
    else       g.cond <= g.cond_in;
  end

  always_comb begin
    hit = (g.rise & g.cond_in & ~g.cond) | (g.fall & ~g.cond_in & g.cond);
    next_event = (g.clr_event ? qsg_pkg::RST_WORD : g.event_word) | hit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) g.event_word <= qsg_pkg::RST_WORD;
    else       g.event_word <= next_event;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)            g.enable <= qsg_pkg::RST_ENABLE;
    else if (g.wr_enable) g.enable <= g.wdata;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      g.fall <= qsg_pkg::RST_FALL;
      g.rise <= qsg_pkg::RST_RISE;
    end else begin
      if (g.wr_fall) g.fall <= g.wdata;
      if (g.wr_rise) g.rise <= g.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) g.summary <= 1'b0;
    else       g.summary <= |(next_event & g.enable);
  end
endmodule : qsg_group_core

// ### sim/qsg_status_sva.sv
// Purpose: Port checks for the status group top.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Read-back checks need the two commands back to back.
`timescale 1ns/1ps
module qsg_status_sva #(
  parameter int WIDTH  = 16,
  parameter int GROUPS = 8
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic                    i_preset,
  input wire logic [GROUPS*WIDTH-1:0] i_cond,
  input wire logic                    i_req,
  input wire logic [2:0]              i_op,
  input wire logic [2:0]              i_group,
  input wire logic [WIDTH-1:0]        i_wdata,
  input wire logic                    o_rvalid,
  input wire logic [WIDTH-1:0]        o_rdata,
  input wire logic [GROUPS-1:0]       o_summary
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire wr_cmd = i_req && i_op inside {qsg_pkg::OP_WR_ENABLE,
    qsg_pkg::OP_WR_FALL, qsg_pkg::OP_WR_RISE};
  wire rd_cmd = i_req && !wr_cmd;
  sequence s_two(w, r);
    i_req && i_op == w ##1 i_req && i_op == r && i_group == $past(i_group);
  endsequence
  property p_back(w, r);
    s_two(w, r) |=> o_rdata == $past(i_wdata, 2);
  endproperty
  AST_RD_ANS: assert property (rd_cmd |=> o_rvalid)
    else $error("read not answered");
  AST_WR_QUIET: assert property (wr_cmd |=> !o_rvalid)
    else $error("write answered");
  AST_IDLE_QUIET: assert property (!i_req |=> !o_rvalid)
    else $error("answer without request");
  AST_RDATA_ZERO: assert property (!o_rvalid |-> o_rdata == '0)
    else $error("read data outside answer");
  AST_RST_QUIET: assert property ($fell(i_rst) |-> !o_rvalid &&
    o_summary == '0) else $error("outputs not cleared by reset");
  AST_EN_BACK: assert property (p_back(qsg_pkg::OP_WR_ENABLE,
    qsg_pkg::OP_RD_ENABLE)) else $error("enable mask not kept");
  AST_FALL_BACK: assert property (p_back(qsg_pkg::OP_WR_FALL,
    qsg_pkg::OP_RD_FALL)) else $error("falling filter not kept");
  AST_RISE_BACK: assert property (p_back(qsg_pkg::OP_WR_RISE,
    qsg_pkg::OP_RD_RISE)) else $error("rising filter not kept");
  AST_PRESET: assert property (i_preset ##0 s_two(qsg_pkg::OP_RD_ENABLE,
    qsg_pkg::OP_RD_ENABLE) |=> o_rdata == $past(o_rdata))
    else $error("preset altered enable mask");
endmodule : qsg_status_sva
bind qsg_status_top qsg_status_sva #(.WIDTH(WIDTH), .GROUPS(GROUPS)) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_preset(i_preset), .i_cond(i_cond),
  .i_req(i_req), .i_op(i_op), .i_group(i_group), .i_wdata(i_wdata),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_summary(o_summary));

// ### sim/doubtful_condition_status_status_groups_test.sv
// Purpose: Self-checking bench for the status group top.
// Assumes: Condition changes reach the event word within five edges.
// Notes:   Each group uses its own bit pair so leakage shows up.
`timescale 1ns/1ps
module doubtful_condition_status_status_groups_test;
  logic         i_clk, i_rst, i_preset, i_req, o_rvalid;
  logic [127:0] i_cond;
  logic [2:0]   i_op, i_group;
  logic [15:0]  i_wdata, o_rdata;
  logic [7:0]   o_summary;
  int           err_count = 0, check_count = 0;
  qsg_status_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_preset(i_preset),
    .i_cond(i_cond), .i_req(i_req), .i_op(i_op), .i_group(i_group),
    .i_wdata(i_wdata), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_summary(o_summary));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic [2:0] op, g, input logic [15:0] d);
    i_req   <= 1'b1;
    i_op    <= op;
    i_group <= g;
    i_wdata <= d;
    @(posedge i_clk);
  endtask : go
  task automatic rd(input logic [2:0] op, g, input logic [15:0] exp);
    go(op, g, 16'h0);
    i_req <= 1'b0;
    @(negedge i_clk);
    chk({15'h0, o_rvalid}, 16'h1);
    chk(o_rdata, exp);
    @(posedge i_clk);
  endtask : rd
  task automatic pair(input logic [2:0] w, r, g, input logic [15:0] d);
    go(w, g, d);
    rd(r, g, d);
  endtask : pair
  task automatic settle(input logic [2:0] g, input logic [15:0] v);
    i_cond[g*16+:16] <= v;
    repeat (5) @(posedge i_clk);
  endtask : settle
  task automatic t_reset();
    for (int g = 0; g < 8; g++) begin
      rd(qsg_pkg::OP_RD_EVENT, 3'(g), 16'h0);
      rd(qsg_pkg::OP_RD_ENABLE, 3'(g), 16'h0);
      rd(qsg_pkg::OP_RD_FALL, 3'(g), 16'h0);
      rd(qsg_pkg::OP_RD_RISE, 3'(g), 16'hffff);
    end
  endtask : t_reset
  task automatic t_edges(input logic [2:0] g);
    logic [15:0] m;
    m = 16'h0101 << g;
    rd(qsg_pkg::OP_RD_EVENT, g, 16'h0);
    pair(qsg_pkg::OP_WR_ENABLE, qsg_pkg::OP_RD_ENABLE, g, m);
    settle(g, m);
    chk({15'h0, o_summary[g]}, 16'h1);
    rd(qsg_pkg::OP_RD_EVENT, g, m);
    rd(qsg_pkg::OP_RD_EVENT, g, 16'h0);
    chk({15'h0, o_summary[g]}, 16'h0);
    rd(qsg_pkg::OP_RD_COND, g, m);
    rd(qsg_pkg::OP_RD_COND, g, m);
    pair(qsg_pkg::OP_WR_FALL, qsg_pkg::OP_RD_FALL, g, m);
    pair(qsg_pkg::OP_WR_RISE, qsg_pkg::OP_RD_RISE, g, 16'h0);
    settle(g, 16'h0);
    rd(qsg_pkg::OP_RD_EVENT, g, m);
    settle(g, m);
    rd(qsg_pkg::OP_RD_EVENT, g, 16'h0);
  endtask : t_edges
  task automatic t_preset();
    i_preset <= 1'b1;
    for (int g = 0; g < 8; g++) begin
      pair(qsg_pkg::OP_RD_ENABLE, qsg_pkg::OP_RD_ENABLE, 3'(g),
        16'h0101 << g);
      rd(qsg_pkg::OP_RD_FALL, 3'(g), 16'h0101 << g);
      rd(qsg_pkg::OP_RD_RISE, 3'(g), 16'h0);
    end
    i_preset <= 1'b0;
  endtask : t_preset
  task automatic end_of_test();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // Whole run is under a thousand cycles; allow ample margin.
  initial begin
    #40000;
    err_count++;
    end_of_test();
  end
  initial begin
    i_rst = 1'b1;
    i_preset = 1'b0;
    i_req = 1'b0;
    i_op = 3'h0;
    i_group = 3'h0;
    i_wdata = 16'h0;
    i_cond = '0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    for (int g = 0; g < 8; g++) begin
      t_edges(3'(g));
    end
    t_preset();
    end_of_test();
  end
endmodule : doubtful_condition_status_status_groups_test
